// ---- hdl/sadc_pkg.sv ----
/*
 Shared constants and types for the serial converter link: frame
 geometry, channel width, conversion timing and host states.
 Assumes both ends run from one 125 MHz ref_clk.
*/
// Function
// - Converter idles until select goes low
// - Result shifts out while address shifts in
// - Host raises select after result bits
// - Host sends bytes MSB first, eight bits
// - Host holds its slave-select input high
// - Host drives on rise, samples on fall
// - Two bytes, sixteen clocks per frame
// - Select low before the first clock edge
// - Byte one: channel out, upper result in
// - Channel address in first byte's upper nibble
// - Converter ignores address input in byte two
// - Byte two returns two LSBs on top
// - Frame returns previous conversion result
// - Done low while converting, high after
// - Host waits for conversion before next frame
// - Bit-bang host uses five port pins
// - Result advances after each falling edge
// - Result output low after ten bits
// - Address captured on rises, first four bits
// - Done falls on tenth falling edge
package sadc_pkg;
    //==========================================================
    // Frame geometry
    //==========================================================
    localparam int RES_BITS   = 10;
    localparam int CHAN_BITS  = 4;
    localparam int BYTE_BITS  = 8;
    localparam int FRAME_BITS = 16;
    localparam logic [RES_BITS-1:0] RES_RESET = 10'h000;
    localparam logic [4:0] DONE_EDGE = 5'h0a;
    //==========================================================
    // Timing
    //==========================================================
    localparam int CLK_PERIOD_NS = 8;
    localparam int CONV_TIME_NS  = 44000;
    localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int SCLK_HALF     = 4;
    localparam int SEL_GAP       = 4;

    typedef logic [CHAN_BITS-1:0] sadc_chan_t;
    typedef logic [RES_BITS-1:0]  sadc_res_t;

    typedef enum logic [2:0]
    {
        SADC_IDLE  = 3'b000,
        SADC_SETUP = 3'b001,
        SADC_HIGH  = 3'b011,
        SADC_LOW   = 3'b010,
        SADC_END   = 3'b110
    } sadc_state_t;
endpackage : sadc_pkg

// ---- hdl/sadc_link_if.sv ----
/*
 Five-wire link between host and converter.
 Assumes the bench drives each modport from one of the two ends.
*/
`timescale 1ns/1ns
interface sadc_link_if;
    logic selN;
    logic sclk;
    logic addrBit;
    logic resBit;
    logic doneFlag;

    modport host
    (
        output selN,
        output sclk,
        output addrBit,
        input  resBit,
        input  doneFlag
    );
    modport conv
    (
        input  selN,
        input  sclk,
        input  addrBit,
        output resBit,
        output doneFlag
    );
endinterface : sadc_link_if

// ---- hdl/sadc_skid_buf.sv ----
/*
 Two-entry valid/ready buffer with honest full and empty.
 Assumes both sides are on ref_clk.
*/
`timescale 1ns/1ns
module sadc_skid_buf #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 2
)
(
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_ff;
    logic [PW-1:0]    rdPtr_ff;
    logic [PW:0]      count_ff;
    logic             push;
    logic             pop;

    assign inReady  = (count_ff != (PW+1)'(DEPTH));
    assign outValid = (count_ff != '0);
    assign outData  = mem[rdPtr_ff];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_ff <= (wrPtr_ff == PW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
            end
            if (pop)
            begin
                rdPtr_ff <= (rdPtr_ff == PW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
            end
            count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : sadc_skid_buf

// ---- hdl/sadc_conv.sv ----
/*
 Converter end: serial slave shifting the previous result out and a
 channel address in, plus a timed stand-in for the conversion.
 Assumes link pins come from outside ref_clk; sampled twice first.
*/
`timescale 1ns/1ns
module sadc_conv
    import sadc_pkg::*;
#(
    parameter int CONV_CYC = sadc_pkg::CONV_CYCLES
)
(
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    sadc_link_if.conv                link,
    input  wire sadc_pkg::sadc_res_t sampleValue,
    output sadc_pkg::sadc_chan_t     chanSel,
    output logic                     convBusy
);
    //==========================================================
    // Pin synchronisers
    //==========================================================
    logic [1:0] selS_ff, clkS_ff, dinS_ff;
    logic       clkPrev_ff;
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            selS_ff    <= 2'h3;
            clkS_ff    <= 2'h0;
            dinS_ff    <= 2'h0;
            clkPrev_ff <= 1'b0;
        end
        else
        begin
            selS_ff    <= {selS_ff[0], link.selN};
            clkS_ff    <= {clkS_ff[0], link.sclk};
            dinS_ff    <= {dinS_ff[0], link.addrBit};
            clkPrev_ff <= clkS_ff[1];
        end
    end
    wire active = !selS_ff[1];
    wire rise   = active && clkS_ff[1] && !clkPrev_ff;
    wire fall   = active && !clkS_ff[1] && clkPrev_ff;

    //==========================================================
    // Shift logic
    //==========================================================
    logic [4:0]        riseCnt_ff, fallCnt_ff;
    logic [RES_BITS-1:0] shift_ff;
    sadc_res_t         result_ff;
    logic [CHAN_BITS-1:0] addr_ff;
    logic              startReq_ff, done_ff, resOut_ff;
    logic [15:0]       convCnt_ff;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            riseCnt_ff  <= '0;
            fallCnt_ff  <= '0;
            shift_ff    <= RES_RESET;
            addr_ff     <= '0;
            resOut_ff   <= 1'b0;
            startReq_ff <= 1'b0;
        end
        else
        begin
            startReq_ff <= 1'b0;
            if (!active)
            begin
                riseCnt_ff <= '0;
                fallCnt_ff <= '0;
                shift_ff   <= result_ff;
                resOut_ff  <= result_ff[RES_BITS-1];
            end
            else
            begin
                if (rise && riseCnt_ff < 5'(CHAN_BITS))
                begin
                    addr_ff    <= {addr_ff[CHAN_BITS-2:0], dinS_ff[1]};
                    riseCnt_ff <= riseCnt_ff + 5'h01;
                end
                if (fall)
                begin
                    fallCnt_ff <= (fallCnt_ff == 5'h1f) ? fallCnt_ff : fallCnt_ff + 5'h01;
                    shift_ff   <= {shift_ff[RES_BITS-2:0], 1'b0};
                    resOut_ff  <= (fallCnt_ff + 5'h01 >= 5'(RES_BITS)) ? 1'b0
                                  : shift_ff[RES_BITS-2];
                    if (fallCnt_ff + 5'h01 == DONE_EDGE)
                    begin
                        startReq_ff <= 1'b1;
                    end
                end
            end
        end
    end

    //==========================================================
    // Conversion timer
    //==========================================================
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            done_ff    <= 1'b1;
            convBusy   <= 1'b0;
            convCnt_ff <= '0;
            result_ff  <= RES_RESET;
            chanSel    <= '0;
        end
        else if (startReq_ff)
        begin
            done_ff    <= 1'b0;
            convBusy   <= 1'b1;
            convCnt_ff <= 16'(CONV_CYC);
            chanSel    <= addr_ff;
        end
        else if (!done_ff)
        begin
            convCnt_ff <= convCnt_ff - 16'h0001;
            if (convCnt_ff == 16'h0001)
            begin
                done_ff   <= 1'b1;
                convBusy  <= 1'b0;
                result_ff <= sampleValue;
            end
        end
    end

    assign link.resBit   = resOut_ff;
    assign link.doneFlag = done_ff;
endmodule : sadc_conv

// ---- hdl/sadc_host.sv ----
/*
 Host end: serial master making select and shift clock by division,
 sending a channel and collecting a 10-bit result per request.
 Assumes requests on ref_clk; result and done pins are asynchronous.
*/
`timescale 1ns/1ns
module sadc_host
    import sadc_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    sadc_link_if.host                 link,
    input  wire logic                 reqValid,
    output logic                      reqReady,
    input  wire sadc_pkg::sadc_chan_t reqChan,
    output logic                      resValid,
    input  wire logic                 resReady,
    output sadc_pkg::sadc_res_t       resData,
    output sadc_pkg::sadc_chan_t      resChan,
    output logic                      ssInN
);
    //==========================================================
    // Synchronisers
    //==========================================================
    logic [1:0] misoS_ff, doneS_ff;
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            misoS_ff <= 2'h0;
            doneS_ff <= 2'h0;
        end
        else
        begin
            misoS_ff <= {misoS_ff[0], link.resBit};
            doneS_ff <= {doneS_ff[0], link.doneFlag};
        end
    end

    //==========================================================
    // Frame engine
    //==========================================================
    sadc_state_t          state_ff;
    logic [3:0]           div_ff;
    logic [4:0]           bitCnt_ff;
    logic [BYTE_BITS-1:0] txByte_ff;
    logic [FRAME_BITS-1:0] rxShift_ff;
    sadc_chan_t           chan_ff;
    logic                 sel_ff, sclk_ff, mosi_ff, bufValid_ff;
    logic                 bufReady;
    wire tick = (div_ff == 4'(SCLK_HALF-1));

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state_ff    <= SADC_IDLE;
            div_ff      <= '0;
            bitCnt_ff   <= '0;
            txByte_ff   <= '0;
            rxShift_ff  <= '0;
            chan_ff     <= '0;
            sel_ff      <= 1'b1;
            sclk_ff     <= 1'b0;
            mosi_ff     <= 1'b0;
            bufValid_ff <= 1'b0;
        end
        else
        begin
            div_ff      <= tick ? '0 : div_ff + 4'h1;
            bufValid_ff <= bufValid_ff & !bufReady;
            case (state_ff)
                SADC_IDLE:
                begin
                    // Waits for conversion done and buffer room
                    if (reqValid && reqReady)
                    begin
                        chan_ff   <= reqChan;
                        txByte_ff <= {reqChan, 4'h0};
                        sel_ff    <= 1'b0;
                        bitCnt_ff <= '0;
                        state_ff  <= SADC_SETUP;
                    end
                end
                SADC_SETUP:
                if (tick)
                begin
                    sclk_ff  <= 1'b1;
                    mosi_ff  <= txByte_ff[BYTE_BITS-1];
                    txByte_ff <= {txByte_ff[BYTE_BITS-2:0], 1'b0};
                    state_ff <= SADC_HIGH;
                end
                SADC_HIGH:
                if (tick)
                begin
                    sclk_ff    <= 1'b0;
                    rxShift_ff <= {rxShift_ff[FRAME_BITS-2:0], misoS_ff[1]};
                    bitCnt_ff  <= bitCnt_ff + 5'h01;
                    state_ff   <= (bitCnt_ff == 5'(FRAME_BITS-1)) ? SADC_END : SADC_LOW;
                end
                SADC_LOW:
                if (tick)
                begin
                    sclk_ff  <= 1'b1;
                    // Second byte carries a repeat of the channel
                    mosi_ff  <= (bitCnt_ff == 5'(BYTE_BITS)) ? chan_ff[CHAN_BITS-1]
                                : txByte_ff[BYTE_BITS-1];
                    txByte_ff <= (bitCnt_ff == 5'(BYTE_BITS)) ? {chan_ff[CHAN_BITS-2:0], 5'h00}
                                 : {txByte_ff[BYTE_BITS-2:0], 1'b0};
                    state_ff <= SADC_HIGH;
                end
                SADC_END:
                if (tick)
                begin
                    sel_ff      <= 1'b1;
                    bufValid_ff <= 1'b1;
                    state_ff    <= SADC_IDLE;
                end
                default:
                    state_ff <= SADC_IDLE;
            endcase
        end
    end

    // Registered ready, high only in the tick cycle; refused while the result path is full
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            reqReady <= 1'b0;
        end
        else
        begin
            reqReady <= (state_ff == SADC_IDLE) && doneS_ff[1] && !bufValid_ff && bufReady
                        && (div_ff == 4'(SCLK_HALF-2));
        end
    end

    //==========================================================
    // Result buffer and registered outputs
    //==========================================================
    logic [CHAN_BITS+RES_BITS-1:0] bufOut;
    logic                          bufOutValid;
    sadc_skid_buf #(
        .WIDTH (CHAN_BITS+RES_BITS),
        .DEPTH (2)
    ) u_buf (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .inValid  (bufValid_ff),
        .inReady  (bufReady),
        .inData   ({chan_ff, rxShift_ff[FRAME_BITS-1:FRAME_BITS-RES_BITS]}),
        .outValid (bufOutValid),
        .outReady (!resValid || resReady),
        .outData  (bufOut)
    );

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            resValid <= 1'b0;
            resData  <= '0;
            resChan  <= '0;
            ssInN    <= 1'b1;
        end
        else
        begin
            ssInN <= 1'b1;
            if (!resValid || resReady)
            begin
                resValid <= bufOutValid;
                {resChan, resData} <= bufOut;
            end
        end
    end

    // Five plain port lines, as a bit-banged host would use
    assign link.selN    = sel_ff;
    assign link.sclk    = sclk_ff;
    assign link.addrBit = mosi_ff;
endmodule : sadc_host

// ---- sim/sadc_link_checker.sv ----
/*
 Concurrent checks on the five link wires between host and converter.
 Assumes it sits beside the link interface on ref_clk with sync rstn.
*/
`timescale 1ns/1ns
module sadc_link_checker #(
    parameter int CONV_CYC = sadc_pkg::CONV_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic selN,
    input wire logic sclk,
    input wire logic addrBit,
    input wire logic resBit,
    input wire logic doneFlag
);
    localparam int LOW_MIN = CONV_CYC - 2;
    localparam int LOW_MAX = CONV_CYC + 6;
    logic        sclkPrev_ff;
    logic        rstnDly_ff;
    logic [4:0]  riseCnt_ff;
    logic [4:0]  fallCnt_ff;
    logic [15:0] lowCnt_ff;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn || !rstnDly_ff);
    //==========================================================
    // Edge counters
    //==========================================================
    always_ff @(posedge ref_clk)
    begin
        sclkPrev_ff <= rstn & sclk;
    end
    // One more edge held off, so no history from before reset is compared
    always_ff @(posedge ref_clk)
    begin
        rstnDly_ff <= rstn;
    end
    always_ff @(posedge ref_clk)
    begin
        if (!rstn || selN)
            riseCnt_ff <= 5'h00;
        else if (sclk && !sclkPrev_ff)
            riseCnt_ff <= riseCnt_ff + 5'h01;
    end
    always_ff @(posedge ref_clk)
    begin
        if (!rstn || selN)
            fallCnt_ff <= 5'h00;
        else if (!sclk && sclkPrev_ff)
            fallCnt_ff <= fallCnt_ff + 5'h01;
    end
    // Width far above any sim conversion time
    always_ff @(posedge ref_clk)
    begin
        if (!rstn || doneFlag)
            lowCnt_ff <= 16'h0000;
        else
            lowCnt_ff <= lowCnt_ff + 16'h0001;
    end
    //==========================================================
    // Assertions
    //==========================================================
    AST_IDLE_CLK_LOW: assert property (selN |-> !sclk)
        else $error("shift clock active while deselected");
    AST_SEL_FIRST: assert property ($rose(sclk) |-> $past(!selN, 2))
        else $error("clock edge without prior select");
    AST_RES_TAIL_LOW: assert property (!selN && fallCnt_ff > 5'h0a |-> !resBit)
        else $error("result line not low after ten bits");
    AST_RES_STEADY: assert property (sclk && $past(sclk) |-> $stable(resBit))
        else $error("result changed while clock high");
    AST_ADDR_STEADY: assert property (!selN && $past(!selN) && !sclk && $past(!sclk)
        |-> $stable(addrBit))
        else $error("address changed while clock low");
    AST_FRAME_SIXTEEN: assert property ($rose(selN)
        |-> riseCnt_ff == 5'h10 && fallCnt_ff == 5'h10)
        else $error("frame not sixteen clocks");
    AST_DONE_TENTH: assert property (!sclk && sclkPrev_ff && !selN && fallCnt_ff == 5'h09
        |-> ##[1:6] $fell(doneFlag))
        else $error("done did not fall after tenth fall");
    AST_DONE_ONLY_TENTH: assert property ($fell(doneFlag) |-> fallCnt_ff == 5'h0a)
        else $error("done fell at wrong edge");
    AST_DONE_SPAN: assert property ($rose(doneFlag)
        |-> lowCnt_ff >= LOW_MIN && lowCnt_ff <= LOW_MAX)
        else $error("conversion time out of range");
    AST_WAIT_DONE: assert property ($fell(selN) |-> doneFlag)
        else $error("frame started during conversion");
endmodule : sadc_link_checker

// ---- sim/testbench.sv ----
/*
 Self-checking bench joining host and converter over the link.
 Assumes the package, interface and both ends are compiled first.
*/
`timescale 1ns/1ns
module testbench;
    import sadc_pkg::*;
    localparam int CONV_T = 20;
    logic        ref_clk     = 1'b0;
    logic        rstn        = 1'b0;
    logic        reqValid    = 1'b0;
    logic        resReady    = 1'b0;
    sadc_chan_t  reqChan     = 4'h0;
    sadc_res_t   sampleValue = 10'h000;
    sadc_res_t   prevSample  = 10'h000;
    logic        sclkPrev    = 1'b0;
    logic [15:0] wireAddr    = 16'h0000;
    logic [15:0] wireRes     = 16'h0000;
    logic        reqReady, resValid, ssInN, convBusy;
    sadc_res_t   resData;
    sadc_chan_t  resChan, chanSel;
    logic [13:0] expQ[$];
    int          failures = 0;
    int          n_tests  = 0;
    int          grants   = 0;
    sadc_chan_t  chans[5] = '{4'h0, 4'h1, 4'h5, 4'ha, 4'hf};
    sadc_res_t   smps[5]  = '{10'h1c2, 10'h3ff, 10'h001, 10'h200, 10'h2aa};

    sadc_link_if lnk();
    sadc_host u_sadc_host (.ref_clk(ref_clk), .rstn(rstn), .link(lnk), .reqValid(reqValid),
        .reqReady(reqReady), .reqChan(reqChan), .resValid(resValid), .resReady(resReady),
        .resData(resData), .resChan(resChan), .ssInN(ssInN));
    sadc_conv #(.CONV_CYC(CONV_T)) u_sadc_conv (.ref_clk(ref_clk), .rstn(rstn), .link(lnk),
        .sampleValue(sampleValue), .chanSel(chanSel), .convBusy(convBusy));
    sadc_link_checker #(.CONV_CYC(CONV_T)) u_chk (.ref_clk(ref_clk), .rstn(rstn),
        .selN(lnk.selN), .sclk(lnk.sclk), .addrBit(lnk.addrBit), .resBit(lnk.resBit),
        .doneFlag(lnk.doneFlag));

    initial forever #4 ref_clk = ~ref_clk;
    //==========================================================
    // Wire monitor: one cycle after each fall both lines settled
    //==========================================================
    always @(posedge ref_clk)
    begin
        sclkPrev <= lnk.sclk;
        if (sclkPrev && !lnk.sclk && !lnk.selN)
        begin
            wireAddr <= {wireAddr[14:0], lnk.addrBit};
            wireRes  <= {wireRes[14:0], lnk.resBit};
        end
    end
    //==========================================================
    // Tasks
    //==========================================================
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic send(input sadc_chan_t ch, input sadc_res_t smp);
        sampleValue <= smp;
        reqChan     <= ch;
        reqValid    <= 1'b1;
        do @(posedge ref_clk); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
        do @(posedge ref_clk); while (lnk.selN !== 1'b0);
        do @(posedge ref_clk); while (lnk.doneFlag !== 1'b0);
        check(16'(convBusy), 16'h0001);
        do @(posedge ref_clk); while (lnk.selN !== 1'b1);
        check(16'(wireAddr[15:12]), 16'(ch));
        check(wireRes, {prevSample, 6'h00});
        do @(posedge ref_clk); while (lnk.doneFlag !== 1'b1);
        check(16'(chanSel), 16'(ch));
        check(16'(convBusy), 16'h0000);
        expQ.push_back({ch, prevSample});
        prevSample = smp;
    endtask : send
    task automatic get_res;
        logic [13:0] e;
        e = expQ.pop_front();
        resReady <= 1'b1;
        do @(posedge ref_clk); while (resValid !== 1'b1);
        check(16'(resData), 16'(e[9:0]));
        check(16'(resChan), 16'(e[13:10]));
        resReady <= 1'b0;
        // Lets an edge pass so a following call never re-raises ready in this step
        @(posedge ref_clk);
    endtask : get_res
    task automatic end_of_test;
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    //==========================================================
    // Sequence
    //==========================================================
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        check(16'(ssInN), 16'h0001);
        check(16'(lnk.doneFlag), 16'h0001);
        for (int i = 0; i < 5; i++)
        begin
            send(chans[i], smps[i]);
            get_res();
        end
        // Receiver stalls: output stage and both buffer entries full, fourth request held off
        send(4'h3, 10'h155);
        send(4'hc, 10'h0aa);
        send(4'h9, 10'h0f0);
        reqChan  <= 4'h6;
        reqValid <= 1'b1;
        repeat (100)
        begin
            @(posedge ref_clk);
            if (reqReady === 1'b1) grants++;
        end
        check(16'(grants), 16'h0000);
        reqValid <= 1'b0;
        get_res();
        get_res();
        get_res();
        send(4'h6, 10'h000);
        get_res();
        end_of_test();
    end
    initial
    begin
        #200000;
        failures++;
        end_of_test();
    end
endmodule : testbench
